// [pkg/ofrc_pkg.sv]
// How it works
// - Vpp present, single-chip: control register at FF80.
// - No Vpp, single-chip: writes ignored, reads FF.
// - Controller compares whole byte with FF for Vpp.
// - Program pulse never exceeds maximum pulse time.
// - Erase pulse never exceeds maximum erase time.
// - Controller waits both verify setup times.
// - No flash read before read setup elapses.
// - Sixteen-bit path, byte and word in two states.
// - Even bytes upper lane, odd bytes lower.
// - Word accesses only at even addresses.
// - Mode pins decode expanded/single and ROM enable.
// - ROM enable uses mode pins and expanded bit.
// - Program, program-verify, erase, erase-verify modes.
// - Thirty-two bytes programmed in one operation.
// - Blocks erased one at a time only.
// - Any combination of blocks selectable for erase.
// - Flash array holds sixty kilobytes.
// - Boot mode measures host bit rate, matches it.
// - Hardware, software, error protection block operations.
// - Both mode pins low: sample three boot pins.
// - Boot data travels on serial channel one pins.
// - Mode 2 without Vpp: registers go external.
// - Vpp flag set enables control register writes, except in mode 1.
package ofrc_pkg;
   localparam logic [15:0] CTRL_ADDR = 16'hFF80;
   localparam logic [15:0] EBLK_ADDR = 16'hFF82;
   localparam logic [15:0] MODE_CONTROL_REG_ADDR = 16'hFFC5;
   localparam logic [7:0] CTRL_RESET = 8'h80;
   localparam logic [7:0] RSVD_READ = 8'hFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] MODE_CONTROL_REG_FIXED = 8'h64;
   localparam logic [7:0] BAUD_ACK = 8'h00;
   localparam logic [15:0] ROM_TOP = 16'hF000;
   localparam int ROM_BYTES = 61440;
   localparam int PAGE_BYTES = 32;
   localparam int NBLK = 8;
   // Block start addresses, last entry is the array end
   localparam logic [8:0][15:0] BLK_BASE = {16'hF000, 16'h8800, 16'h4800, 16'h1800,
      16'h1000, 16'h0C00, 16'h0800, 16'h0400, 16'h0000};
   localparam int BIT_VPP = 7;
   localparam int BIT_LOCK = 6;
   localparam int BIT_EV = 3;
   localparam int BIT_PV = 2;
   localparam int BIT_E = 1;
   localparam int BIT_P = 0;
   localparam int PIN_VPP = 5;
   localparam int PIN_HI = 4;
   localparam int PIN_BOOT = 0;
   localparam logic [1:0] MODE_BOOT = 2'b00;
   localparam logic [1:0] MODE_EXP_NOROM = 2'b01;
   localparam logic [1:0] MODE_EXP_ROM = 2'b10;
   localparam logic [1:0] MODE_SINGLE = 2'b11;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_PROG = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam int CLK_MHZ = 40;
   localparam int PROG_PULSE_US = 1000;
   localparam int ERASE_PULSE_S = 30;
   localparam int VS1_US = 4;
   localparam int VS2_US = 2;
   localparam int FRS_HI_US = 50;
   localparam int FRS_LO_US = 100;
   localparam int PROG_MAX_CYC = PROG_PULSE_US * CLK_MHZ;
   localparam int ERASE_MAX_CYC = ERASE_PULSE_S * 1000000 * CLK_MHZ;
   localparam int VS1_CYC = VS1_US * CLK_MHZ;
   localparam int VS2_CYC = VS2_US * CLK_MHZ;
   localparam int FRS_HI_CYC = FRS_HI_US * CLK_MHZ;
   localparam int FRS_LO_CYC = FRS_LO_US * CLK_MHZ;
   localparam int STEP_OVH = 2;
endpackage

// [pkg/ofrc_if.sv]
`timescale 1ns/1ps
interface ofrc_if;
   logic [15:0] bus_addr;
   logic [15:0] bus_wdata;
   logic bus_rd;
   logic bus_wr;
   logic bus_word;
   logic [15:0] bus_rdata;
   logic bus_ack;
   logic bus_ext;
   logic program_voltage_pin;
   logic mode_pin_hi;
   logic mode_pin_lo;
   logic [2:0] boot_select_port;
   logic serial_rx_pin;
   logic serial_tx_pin;
   modport dev (input bus_addr, bus_wdata, bus_rd, bus_wr, bus_word, program_voltage_pin,
      mode_pin_hi, mode_pin_lo, boot_select_port, serial_rx_pin,
      output bus_rdata, bus_ack, bus_ext, serial_tx_pin);
   modport host (output bus_addr, bus_wdata, bus_rd, bus_wr, bus_word, program_voltage_pin,
      mode_pin_hi, mode_pin_lo, boot_select_port, serial_rx_pin,
      input bus_rdata, bus_ack, bus_ext, serial_tx_pin);
endinterface

// [hw/ofrc_autobaud.sv]
`timescale 1ns/1ps
module ofrc_autobaud
   import ofrc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic enable,
   input wire logic rx_pin,
   output logic locked,
   output logic tx
);
   typedef enum logic [1:0] {AB_IDLE, AB_MEAS, AB_SEND, AB_DONE} ofrc_ab_st_t;
   typedef struct packed {
      logic [2:0] rx_s;
      logic rx;
      ofrc_ab_st_t st;
      logic [15:0] cnt;
      logic [15:0] bitc;
      logic [3:0] bitn;
      logic lock;
      logic tx;
   } ofrc_ab_t;
   ofrc_ab_t q, n;

   // Start-bit width measurement, then an answer byte at that rate
   always_comb begin
      n = q;
      n.rx_s = {q.rx_s[1:0], rx_pin};
      if (q.rx_s[1] == q.rx_s[2]) begin
         n.rx = q.rx_s[2];
      end
      if (srst) begin
         n.rx = 1'b1;
         n.st = AB_IDLE;
         n.cnt = '0;
         n.bitc = '0;
         n.bitn = '0;
         n.lock = 1'b0;
         n.tx = 1'b1;
      end else begin
         case (q.st)
            AB_IDLE: begin
               if (enable && !q.rx) begin
                  n.st = AB_MEAS;
                  n.cnt = 16'h0001;
               end
            end
            AB_MEAS: begin
               if (q.rx) begin
                  n.bitc = q.cnt;
                  n.lock = 1'b1;
                  n.st = AB_SEND;
                  n.cnt = '0;
                  n.bitn = '0;
                  n.tx = 1'b0;
               end else if (q.cnt != 16'hFFFF) begin
                  n.cnt = q.cnt + 16'h0001;
               end
            end
            AB_SEND: begin
               if (q.cnt == q.bitc - 16'h0001) begin
                  n.cnt = '0;
                  n.bitn = q.bitn + 4'h1;
                  if (q.bitn == 4'h8) begin
                     n.tx = 1'b1;
                  end else if (q.bitn == 4'h9) begin
                     n.st = AB_DONE;
                  end else begin
                     n.tx = BAUD_ACK[q.bitn[2:0]];
                  end
               end else begin
                  n.cnt = q.cnt + 16'h0001;
               end
            end
            AB_DONE: begin
               if (!enable) begin
                  n.st = AB_IDLE;
               end
            end
            default: n.st = AB_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      q <= n;
   end

   assign locked = q.lock;
   assign tx = q.tx;
endmodule

// [hw/ofrc_flash_dev.sv]
`timescale 1ns/1ps
module ofrc_flash_dev
   import ofrc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SRST,
   ofrc_if.dev BUS,
   output logic ROM_ENABLE,
   output logic [2:0] BOOT_SELECT,
   output logic HV_FLAG,
   output logic [2:0] PROTECT,
   output logic ERASE_BUSY,
   output logic BAUD_LOCK
);
   typedef struct packed {
      logic [2:0][5:0] pin_s;
      logic vpp;
      logic [1:0] mode;
      logic [2:0] boot;
      logic expanded_mode_enable;
      logic [7:0] ctrl;
      logic [7:0] eblk;
      logic err;
      logic [15:0] rdata;
      logic ack;
      logic ext;
      logic [10:0] page;
      logic [PAGE_BYTES-1:0][7:0] pbuf;
      logic prog_go;
      logic [15:0] eptr;
      logic rom_en;
      logic [2:0] prot;
      logic ebusy;
   } ofrc_dev_t;
   ofrc_dev_t q, n;
   logic [7:0] mem [0:ROM_BYTES-1];
   logic erase_we;

   // Block number of a flash address
   function automatic logic [2:0] blk_of(input logic [15:0] a);
      logic [2:0] b;
      b = 3'h0;
      for (int i = 1; i < NBLK; i++) begin
         if (a >= BLK_BASE[i]) begin
            b = 3'(i);
         end
      end
      return b;
   endfunction

   // Byte placed on its lane of the data path
   function automatic logic [15:0] lane(input logic odd, input logic [7:0] b);
      return odd ? {8'h00, b} : {b, 8'h00};
   endfunction

   // Pin sampling, register decode, program buffer and erase walk
   always_comb begin
      logic [7:0] wb;
      logic [7:0] nc;
      logic [15:0] ra;
      logic hwp;
      logic prot;
      logic vis;
      logic rsvd;
      logic busy;
      logic both;
      logic rom_hit;
      wb = BUS.bus_addr[0] ? BUS.bus_wdata[7:0] : BUS.bus_wdata[15:8];
      nc = wb;
      ra = {BUS.bus_addr[15:1], BUS.bus_addr[0] & !BUS.bus_word};
      hwp = !q.vpp || q.mode == MODE_EXP_NOROM;
      prot = hwp || q.ctrl[BIT_LOCK] || q.err;
      vis = q.vpp && q.mode != MODE_EXP_NOROM;
      rsvd = (q.mode == MODE_EXP_NOROM) ? q.vpp : (q.mode != MODE_EXP_ROM && !q.vpp);
      busy = q.ctrl[BIT_P] || q.ctrl[BIT_E];
      both = nc[BIT_P] && nc[BIT_E];
      rom_hit = ra < ROM_TOP && q.rom_en;
      erase_we = 1'b0;
      n = q;
      n.pin_s = {q.pin_s[1:0], {BUS.program_voltage_pin, BUS.mode_pin_hi, BUS.mode_pin_lo,
         BUS.boot_select_port}};
      if (q.pin_s[1][PIN_VPP] == q.pin_s[2][PIN_VPP]) begin
         n.vpp = q.pin_s[2][PIN_VPP];
      end
      if (SRST) begin
         n.vpp = 1'b0;
         n.mode = q.pin_s[2][PIN_HI -: 2];
         n.boot = (q.pin_s[2][PIN_HI -: 2] == MODE_BOOT) ? q.pin_s[2][PIN_BOOT +: 3] : 3'h0;
         n.expanded_mode_enable = q.pin_s[2][PIN_HI -: 2] == MODE_EXP_NOROM;
         n.ctrl = CTRL_RESET;
         n.eblk = '0;
         n.err = 1'b0;
         n.rdata = '0;
         n.ack = 1'b0;
         n.ext = 1'b0;
         n.page = '0;
         n.pbuf = '1;
         n.prog_go = 1'b0;
         n.eptr = '0;
         n.rom_en = 1'b0;
         n.prot = '0;
         n.ebusy = 1'b0;
      end else begin
         n.ack = BUS.bus_rd || BUS.bus_wr;
         n.ext = 1'b0;
         n.prog_go = 1'b0;
         if (q.prog_go) begin
            n.pbuf = '1;
         end
         if (BUS.bus_rd || BUS.bus_wr) begin
            if (BUS.bus_addr == CTRL_ADDR || BUS.bus_addr == EBLK_ADDR) begin
               if (vis) begin
                  if (BUS.bus_rd) begin
                     n.rdata = lane(1'b0, (BUS.bus_addr == CTRL_ADDR) ?
                        {q.vpp, q.ctrl[BIT_LOCK:0]} : q.eblk);
                  end else if (BUS.bus_addr == CTRL_ADDR) begin
                     // Writes accepted once the Vpp flag is set, except in mode 1
                     n.err = q.err || both;
                     n.ctrl[BIT_LOCK] = nc[BIT_LOCK];
                     n.ctrl[BIT_EV:BIT_P] = (prot || both) ? 4'h0 : nc[BIT_EV:BIT_P];
                     n.prog_go = nc[BIT_P] && !q.ctrl[BIT_P] && !prot && !both;
                  end else begin
                     n.eblk = wb;
                  end
               end else if (rsvd) begin
                  // Writes fall away, only reads see all ones
                  if (BUS.bus_rd) begin
                     n.rdata = {RSVD_READ, RSVD_READ};
                  end
               end else begin
                  n.ext = 1'b1;
               end
            end else if (BUS.bus_addr == MODE_CONTROL_REG_ADDR) begin
               if (BUS.bus_rd) begin
                  n.rdata = lane(1'b1, MODE_CONTROL_REG_FIXED | {q.expanded_mode_enable, 5'h00, q.mode});
               end else if (q.mode == MODE_BOOT) begin
                  n.expanded_mode_enable = wb[BIT_VPP];
               end
            end else if (rom_hit) begin
               if (busy) begin
                  n.err = 1'b1;
               end
               if (BUS.bus_rd) begin
                  n.rdata = BUS.bus_word ? {mem[ra], mem[ra | 16'h0001]} :
                     lane(ra[0], mem[ra]);
               end else if (!prot) begin
                  n.page = ra[15:5];
                  if (BUS.bus_word) begin
                     n.pbuf[ra[4:0]] = BUS.bus_wdata[15:8];
                     n.pbuf[ra[4:0] | 5'h01] = BUS.bus_wdata[7:0];
                  end else begin
                     n.pbuf[ra[4:0]] = wb;
                  end
               end
            end else begin
               n.ext = 1'b1;
            end
         end
         // Erase walks the array one byte per cycle while E is held
         if (q.ctrl[BIT_E] && !prot) begin
            if (q.eptr < ROM_TOP) begin
               n.eptr = q.eptr + 16'h0001;
               erase_we = q.eblk[blk_of(q.eptr)];
            end
         end else begin
            n.eptr = '0;
         end
         if (prot) begin
            n.ctrl[BIT_EV:BIT_P] = 4'h0;
         end
         n.rom_en = (q.mode == MODE_BOOT) ? !q.expanded_mode_enable : (q.mode != MODE_EXP_NOROM);
         n.prot = {q.err, q.ctrl[BIT_LOCK], hwp};
         n.ebusy = q.ctrl[BIT_E] && !prot && q.eptr < ROM_TOP;
      end
   end

   always_ff @(posedge REF_CLK) begin
      q <= n;
   end

   // Flash array: page program clears bits, erase sets bytes
   always_ff @(posedge REF_CLK) begin
      if (q.prog_go) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            mem[{q.page, 5'(i)}] <= mem[{q.page, 5'(i)}] & q.pbuf[i];
         end
      end
      if (erase_we) begin
         mem[q.eptr] <= ERASED_BYTE;
      end
   end

   ofrc_autobaud u_baud (
      .clk(REF_CLK),
      .srst(SRST),
      .enable(q.mode == MODE_BOOT),
      .rx_pin(BUS.serial_rx_pin),
      .locked(BAUD_LOCK),
      .tx(BUS.serial_tx_pin)
   );

   assign BUS.bus_rdata = q.rdata;
   assign BUS.bus_ack = q.ack;
   assign BUS.bus_ext = q.ext;
   assign ROM_ENABLE = q.rom_en;
   assign BOOT_SELECT = q.boot;
   assign HV_FLAG = q.vpp;
   assign PROTECT = q.prot;
   assign ERASE_BUSY = q.ebusy;
endmodule

// [hw/ofrc_flash_host.sv]
`timescale 1ns/1ps
module ofrc_flash_host
   import ofrc_pkg::*;
#(
   parameter int PROG_CYC = PROG_MAX_CYC,
   parameter int ERASE_CYC = ERASE_MAX_CYC,
   parameter int FRS_CYC = FRS_LO_CYC
)(
   input wire logic REF_CLK,
   input wire logic SRST,
   ofrc_if.host BUS,
   input wire logic [1:0] MODE_SEL,
   input wire logic [2:0] BOOT_SEL,
   input wire logic VPP_REQ,
   input wire logic RX_LEVEL,
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_OP,
   input wire logic [15:0] CMD_ADDR,
   input wire logic [15:0] CMD_DATA,
   input wire logic CMD_WORD,
   output logic CMD_READY,
   output logic RESULT_VALID,
   output logic [15:0] RESULT_DATA,
   output logic RESULT_ERR
);
   typedef enum logic [2:0] {H_IDLE, H_ACC, H_CHK, H_STEP, H_WAIT} ofrc_hst_t;
   typedef struct packed {
      ofrc_hst_t st;
      logic [1:0] op;
      logic [2:0] step;
      logic [2:0] blk;
      logic [7:0] mask;
      logic [30:0] wcnt;
      logic [30:0] frs;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic rd;
      logic wr;
      logic word;
      logic vpp;
      logic [1:0] mode;
      logic [2:0] boot;
      logic rx;
      logic ready;
      logic rv;
      logic [15:0] rdat;
      logic rerr;
   } ofrc_host_t;
   ofrc_host_t q, n;

   // Lowest selected block
   function automatic logic [2:0] first_blk(input logic [7:0] m);
      logic [2:0] b;
      b = 3'h0;
      for (int i = NBLK - 1; i >= 0; i--) begin
         if (m[i]) begin
            b = 3'(i);
         end
      end
      return b;
   endfunction

   // Command sequencer and pin drive
   always_comb begin
      logic [7:0] sv;
      logic [30:0] sw;
      logic se;
      logic last;
      n = q;
      n.rd = 1'b0;
      n.wr = 1'b0;
      n.rv = 1'b0;
      // Step table: register, value and hold time of each step
      se = 1'b0;
      sv = 8'h00;
      sw = '0;
      last = 1'b0;
      case ({q.op == OP_ERASE, q.step})
         4'h0: begin
            sv[BIT_P] = 1'b1;
            sw = 31'(PROG_CYC - STEP_OVH);
         end
         4'h1: sw = 31'(VS1_CYC);
         4'h2: begin
            sv[BIT_PV] = 1'b1;
            sw = 31'(VS2_CYC);
         end
         4'h8: begin
            se = 1'b1;
            sv = 8'h01 << q.blk;
         end
         4'h9: begin
            sv[BIT_E] = 1'b1;
            sw = 31'(ERASE_CYC - STEP_OVH);
         end
         4'hA: sw = 31'(VS1_CYC);
         4'hB: begin
            sv[BIT_EV] = 1'b1;
            sw = 31'(VS2_CYC);
         end
         default: last = 1'b1;
      endcase
      n.vpp = VPP_REQ;
      n.mode = MODE_SEL;
      n.boot = BOOT_SEL;
      n.rx = RX_LEVEL;
      if (q.vpp && !VPP_REQ) begin
         n.frs = 31'(FRS_CYC);
      end else if (q.frs != '0) begin
         n.frs = q.frs - 31'h1;
      end
      if (SRST) begin
         n = '0;
         n.st = H_IDLE;
         n.mode = MODE_SINGLE;
         n.rx = 1'b1;
         n.frs = 31'(FRS_CYC);
      end else begin
         case (q.st)
            H_IDLE: begin
               if (CMD_VALID && q.ready) begin
                  n.op = CMD_OP;
                  n.addr = (CMD_OP[1]) ? CTRL_ADDR : CMD_ADDR;
                  n.word = CMD_WORD && !CMD_ADDR[0] && !CMD_OP[1];
                  n.wdata = CMD_DATA;
                  n.rd = CMD_OP != OP_WRITE;
                  n.wr = CMD_OP == OP_WRITE;
                  n.mask = CMD_DATA[7:0];
                  n.blk = first_blk(CMD_DATA[7:0]);
                  n.step = '0;
                  n.st = CMD_OP[1] ? H_CHK : H_ACC;
               end
            end
            H_ACC: begin
               if (BUS.bus_ack) begin
                  n.rv = 1'b1;
                  n.rdat = BUS.bus_rdata;
                  n.rerr = BUS.bus_ext;
                  n.st = H_IDLE;
               end
            end
            H_CHK: begin
               if (BUS.bus_ack) begin
                  n.rdat = BUS.bus_rdata;
                  if (BUS.bus_ext || BUS.bus_rdata[15:8] == RSVD_READ) begin
                     n.rv = 1'b1;
                     n.rerr = 1'b1;
                     n.st = H_IDLE;
                  end else begin
                     n.rerr = 1'b0;
                     n.st = H_STEP;
                  end
               end
            end
            H_STEP: begin
               if (last) begin
                  n.mask[q.blk] = 1'b0;
                  if (q.op == OP_ERASE && n.mask != 8'h00) begin
                     n.blk = first_blk(n.mask);
                     n.step = '0;
                  end else begin
                     n.rv = 1'b1;
                     n.st = H_IDLE;
                  end
               end else begin
                  n.wr = 1'b1;
                  n.word = 1'b0;
                  n.addr = se ? EBLK_ADDR : CTRL_ADDR;
                  n.wdata = {sv, 8'h00};
                  n.wcnt = sw;
                  n.st = H_WAIT;
               end
            end
            H_WAIT: begin
               if (q.wcnt == '0) begin
                  n.step = q.step + 3'h1;
                  n.st = H_STEP;
               end else begin
                  n.wcnt = q.wcnt - 31'h1;
               end
            end
            default: n.st = H_IDLE;
         endcase
      end
      n.ready = n.st == H_IDLE && n.frs == '0 && !n.rv;
   end

   always_ff @(posedge REF_CLK) begin
      q <= n;
   end

   assign BUS.bus_addr = q.addr;
   assign BUS.bus_wdata = q.wdata;
   assign BUS.bus_rd = q.rd;
   assign BUS.bus_wr = q.wr;
   assign BUS.bus_word = q.word;
   assign BUS.program_voltage_pin = q.vpp;
   assign BUS.mode_pin_hi = q.mode[1];
   assign BUS.mode_pin_lo = q.mode[0];
   assign BUS.boot_select_port = q.boot;
   assign BUS.serial_rx_pin = q.rx;
   assign CMD_READY = q.ready;
   assign RESULT_VALID = q.rv;
   assign RESULT_DATA = q.rdat;
   assign RESULT_ERR = q.rerr;
endmodule

// [tb/ofrc_properties.sv]
`timescale 1ns/1ps
module ofrc_properties
   import ofrc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic [15:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [15:0] bus_rdata,
   input wire logic bus_ack,
   input wire logic bus_ext,
   input wire logic program_voltage_pin,
   input wire logic mode_pin_hi,
   input wire logic mode_pin_lo,
   input wire logic serial_tx_pin
);
   // All checks run on the single system clock
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);

   // Bus answer timing and lane rules
   AST_ACK_AFTER_REQ: assert property ((bus_rd || bus_wr) |=> bus_ack)
      else $error("no answer one cycle after request");
   AST_ACK_CAUSE: assert property (bus_ack |-> $past(bus_rd || bus_wr))
      else $error("answer without request");
   AST_RDATA_HOLD: assert property (bus_wr |=> $stable(bus_rdata))
      else $error("read data moved on a write");
   AST_WORD_EVEN: assert property ((bus_rd || bus_wr) && bus_word |-> !bus_addr[0])
      else $error("word access at odd address");
   AST_ODD_LOWER: assert property (bus_rd && !bus_word && bus_addr[0]
      && bus_addr < ROM_TOP |=> bus_ext || bus_rdata[15:8] == 8'h00)
      else $error("odd byte not on lower lane");
   AST_EVEN_UPPER: assert property (bus_rd && !bus_word && !bus_addr[0]
      && bus_addr < ROM_TOP |=> bus_ext || bus_rdata[7:0] == 8'h00)
      else $error("even byte not on upper lane");
   // Control register visibility without high voltage
   AST_CTRL_NO_HV: assert property ((!program_voltage_pin)[*5] ##0 (bus_rd &&
      bus_addr == CTRL_ADDR && mode_pin_hi && mode_pin_lo)
      |=> bus_rdata[15:8] == RSVD_READ && !bus_ext)
      else $error("control location not reserved without high voltage");
   AST_MODE2_EXT: assert property ((!program_voltage_pin)[*5] ##0 (bus_rd &&
      bus_addr == CTRL_ADDR && mode_pin_hi && !mode_pin_lo) |=> bus_ext)
      else $error("control access not external in expanded mode");
   AST_EXT_ONLY_ACK: assert property (bus_ext |-> bus_ack)
      else $error("external flag without answer");
   AST_TX_BOOT: assert property ($fell(serial_tx_pin) |-> !mode_pin_hi && !mode_pin_lo)
      else $error("serial output active outside boot mode");
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   import ofrc_pkg::*;
   logic REF_CLK, rst_h, rst_d, vpp, rx, valid, word, ready, rvalid, rerr;
   logic rom_en, hv, ebusy, blk;
   logic [1:0] mode, op;
   logic [2:0] boot, bsel, prot;
   logic [15:0] addr, data, rdata;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int busy_cycles = 0;

   ofrc_if bus_if();
   ofrc_flash_dev ofrc_flash_dev_inst(.REF_CLK(REF_CLK), .SRST(rst_d), .BUS(bus_if.dev),
      .ROM_ENABLE(rom_en), .BOOT_SELECT(bsel), .HV_FLAG(hv), .PROTECT(prot),
      .ERASE_BUSY(ebusy), .BAUD_LOCK(blk));
   ofrc_flash_host #(.PROG_CYC(20), .ERASE_CYC(70000), .FRS_CYC(10)) ofrc_flash_host_inst(
      .REF_CLK(REF_CLK), .SRST(rst_h), .BUS(bus_if.host), .MODE_SEL(mode), .BOOT_SEL(boot),
      .VPP_REQ(vpp), .RX_LEVEL(rx), .CMD_VALID(valid), .CMD_OP(op), .CMD_ADDR(addr),
      .CMD_DATA(data), .CMD_WORD(word), .CMD_READY(ready), .RESULT_VALID(rvalid),
      .RESULT_DATA(rdata), .RESULT_ERR(rerr));
   ofrc_properties ofrc_properties_inst(.REF_CLK(REF_CLK), .SRST(rst_d),
      .bus_addr(bus_if.bus_addr), .bus_rd(bus_if.bus_rd), .bus_wr(bus_if.bus_wr),
      .bus_word(bus_if.bus_word), .bus_rdata(bus_if.bus_rdata), .bus_ack(bus_if.bus_ack),
      .bus_ext(bus_if.bus_ext), .program_voltage_pin(bus_if.program_voltage_pin),
      .mode_pin_hi(bus_if.mode_pin_hi), .mode_pin_lo(bus_if.mode_pin_lo),
      .serial_tx_pin(bus_if.serial_tx_pin));

   // 40 MHz clock
   initial begin
      REF_CLK = 0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end

   // Counts erase walk cycles and cuts a hung run short
   always @(posedge REF_CLK) begin
      cycles++;
      if (ebusy === 1'b1) begin
         busy_cycles++;
      end
      if (cycles == 95000) begin
         miscompares++;
         final_report;
      end
   end

   task final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge REF_CLK);
      #2;
   endtask

   // Host leaves reset first so the device latches the chosen mode pins
   task restart(input logic [1:0] m, input logic v);
      rst_h = 1;
      rst_d = 1;
      mode = m;
      vpp = v;
      tick(20);
      rst_h = 0;
      tick(8);
      rst_d = 0;
      tick(15);
   endtask

   // One host command, waits for ready and for the result pulse
   task cmd(input logic [1:0] o, input logic [15:0] a, input logic [15:0] d, input logic w);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 1000) begin
         tick(1);
         n++;
      end
      if (n >= 1000)
         check("ready wait", 16'h0000, 16'h0001);
      valid = 1;
      op = o;
      addr = a;
      data = d;
      word = w;
      tick(1);
      valid = 0;
      n = 0;
      while (rvalid !== 1'b1 && n < 80000) begin
         tick(1);
         n++;
      end
      if (n >= 80000)
         check("result wait", 16'h0000, 16'h0001);
   endtask

   // Main sequence
   initial begin
      rst_h = 1;
      rst_d = 1;
      vpp = 0;
      rx = 1;
      valid = 0;
      word = 0;
      mode = 2'b11;
      op = OP_READ;
      boot = 3'h0;
      addr = 16'h0000;
      data = 16'h0000;
      restart(2'b11, 1'b0);
      check("rom enable single", {15'h0, rom_en}, 16'h0001);
      check("hw protect", {15'h0, prot[0]}, 16'h0001);
      cmd(OP_WRITE, CTRL_ADDR, 16'h0300, 1'b0);
      cmd(OP_READ, CTRL_ADDR, 16'h0000, 1'b0);
      check("ctrl without hv", {rdata[15:8], 8'h00}, 16'hFF00);
      $display("test no_hv done");
      restart(2'b11, 1'b1);
      check("hv flag", {15'h0, hv}, 16'h0001);
      cmd(OP_READ, CTRL_ADDR, 16'h0000, 1'b0);
      check("ctrl reset", {rdata[15:8], 7'h0, rerr}, 16'h8000);
      cmd(OP_WRITE, CTRL_ADDR, 16'h4000, 1'b0);
      cmd(OP_READ, CTRL_ADDR, 16'h0000, 1'b0);
      check("ctrl written", {rdata[15:8], 8'h00}, 16'hC000);
      check("sw protect", {15'h0, prot[1]}, 16'h0001);
      cmd(OP_WRITE, CTRL_ADDR, 16'h0300, 1'b0);
      check("error protect", {15'h0, prot[2]}, 16'h0001);
      $display("test hv_ctrl done");
      restart(2'b11, 1'b1);
      cmd(OP_ERASE, 16'h0000, 16'h0001, 1'b0);
      check("erase err", {15'h0, rerr}, 16'h0000);
      check("erase busy cycles", 16'(busy_cycles), 16'(ROM_BYTES));
      cmd(OP_READ, 16'h0010, 16'h0000, 1'b0);
      check("erased byte", rdata, 16'hFF00);
      cmd(OP_WRITE, 16'h0000, 16'hA55A, 1'b1);
      cmd(OP_WRITE, 16'h0003, 16'h00C3, 1'b0);
      cmd(OP_PROG, 16'h0000, 16'h0000, 1'b0);
      check("program err", {15'h0, rerr}, 16'h0000);
      cmd(OP_READ, 16'h0000, 16'h0000, 1'b1);
      check("word back", rdata, 16'hA55A);
      cmd(OP_READ, 16'h0003, 16'h0000, 1'b0);
      check("odd byte", rdata, 16'h00C3);
      cmd(OP_READ, 16'h0002, 16'h0000, 1'b0);
      check("even byte", rdata, 16'hFF00);
      $display("test program done");
      restart(2'b10, 1'b0);
      check("rom enable mode2", {15'h0, rom_en}, 16'h0001);
      cmd(OP_READ, CTRL_ADDR, 16'h0000, 1'b0);
      check("ctrl external", {15'h0, rerr}, 16'h0001);
      restart(2'b01, 1'b0);
      check("rom enable mode1", {15'h0, rom_en}, 16'h0000);
      $display("test modes done");
      boot = 3'h5;
      restart(2'b00, 1'b1);
      check("boot select", {13'h0, bsel}, 16'h0005);
      check("rom enable boot", {15'h0, rom_en}, 16'h0001);
      rx = 0;
      tick(16);
      rx = 1;
      tick(200);
      check("baud lock", {15'h0, blk}, 16'h0001);
      cmd(OP_WRITE, MODE_CONTROL_REG_ADDR, 16'h0080, 1'b0);
      tick(3);
      check("rom off by expanded_mode_enable", {15'h0, rom_en}, 16'h0000);
      $display("test boot done");
      final_report;
   end
endmodule
